/* rtl/qbpl_line.sv */
`timescale 1ns/10ps
// one quasi-bidirectional port: strong low for 0, weak high otherwise
module qbpl_line (
    input  wire logic [7:0] latch,        // latch value
    input  wire logic [7:0] alt_en,       // alternate output select
    input  wire logic [7:0] alt_val,      // alternate output value
    output qbpl_pkg::qbpl_pin_s pins      // pin drive
);

    logic [7:0] eff;                      // effective output level

    // merge latch with alternate output, a 1 latch lets alt drive
    always_comb begin
        eff = latch & ((~alt_en) | alt_val);
        pins.pin_out = eff;
        pins.pin_oe  = ~eff;              // drive only low, weak pullup otherwise
    end

endmodule : qbpl_line

/* rtl/qbpl_pkg.sv */
package qbpl_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] PORT_ZERO_OFS  = 8'h80;
    localparam logic [7:0] PORT_ONE_OFS   = 8'h90;
    localparam logic [7:0] PORT_TWO_OFS   = 8'ha0;
    localparam logic [7:0] PORT_THREE_OFS = 8'hb0;

    // latch reset value, all lines in input mode
    localparam logic [7:0] LATCH_RESET    = 8'hff;

    // port three alternate function bit positions
    localparam int RXD_BIT   = 0;
    localparam int TXD_BIT   = 1;
    localparam int IRQ0_BIT  = 2;
    localparam int IRQ1_BIT  = 3;
    localparam int T0_BIT    = 4;
    localparam int T1_BIT    = 5;

    localparam int NUM_PORTS = 4;
    localparam int PORT_W    = 8;

    // ahb transfer encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    // one port's pin signals
    typedef struct packed {
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } qbpl_pin_s;

endpackage : qbpl_pkg

/* rtl/qbpl_top.sv */
`timescale 1ns/10ps
module qbpl_top (
    input  wire logic        hclk,                 // system clock
    input  wire logic        hresetn,              // async reset, low
    input  wire logic        hsel,                 // slave select
    input  wire logic [31:0] haddr,                // address
    input  wire logic [1:0]  htrans,               // transfer type
    input  wire logic        hwrite,               // write
    input  wire logic [2:0]  hsize,                // size
    input  wire logic        hready,               // bus ready in
    input  wire logic [31:0] hwdata,               // write data
    output logic      [31:0] hrdata,               // read data
    output logic             hreadyout,            // slave ready
    output logic             hresp,                // response, always okay
    input  wire logic [31:0] pin_in,               // pin levels, port n at [8n+7:8n]
    output logic      [31:0] pin_out,              // pin output levels
    output logic      [31:0] pin_oe,               // pin low drive enables
    input  wire logic        uart_txd,             // uart transmit / shift clock
    input  wire logic        uart_tx_en,           // uart owns transmit line
    output logic             uart_rxd,             // uart receive data
    output logic             timer_zero_count_input, // timer 0 count
    output logic             timer_one_count_input,  // timer 1 count
    output logic             ext_irq_zero_n,       // ext irq 0, low
    output logic             ext_irq_one_n         // ext irq 1, low
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [3:0][7:0] latch_ff;        // port latches
        logic            wr_pend_ff;      // write data phase pending
        logic [1:0]      wr_idx_ff;       // target port of pending write
        logic            wr_ok_ff;        // pending write hits a port
        logic [31:0]     rdata_ff;        // read data
    } qbpl_state_s;

    qbpl_state_s st_ff;                   // registered state
    qbpl_state_s nxt_st;                  // next state

    localparam int         PORT_THREE_NUM = 3;     // port carrying the alternate functions
    localparam logic [1:0] PORT_THREE_IDX = 2'd3;  // same port as a decoded index

    logic [2:0]      addr_dec;            // raw decode result, hit flag and index
    logic            addr_ok;             // address decodes to a port
    logic [1:0]      addr_idx;            // decoded port index
    logic            access;              // valid address phase
    logic [31:0]     pin_vec;             // pin drive outputs
    logic [31:0]     oe_vec;              // pin enables
    logic [7:0]      p3_rd;               // port three readback

    ////////////////////////////////////////////////////////////////////////
    // address decode function

    function automatic logic [2:0] qbpl_decode(input logic [7:0] a);
        case (a)
            qbpl_pkg::PORT_ZERO_OFS:  qbpl_decode = 3'b100;
            qbpl_pkg::PORT_ONE_OFS:   qbpl_decode = 3'b101;
            qbpl_pkg::PORT_TWO_OFS:   qbpl_decode = 3'b110;
            qbpl_pkg::PORT_THREE_OFS: qbpl_decode = 3'b111;
            default:                  qbpl_decode = 3'b000;
        endcase
    endfunction : qbpl_decode

    // flat pin position of one bit of one port
    function automatic int qbpl_pin_pos(input int port_n, input int bit_n);
        qbpl_pin_pos = port_n * qbpl_pkg::PORT_W + bit_n;
    endfunction : qbpl_pin_pos

    // upper address bits must be zero for a hit
    always_comb begin
        addr_dec = qbpl_decode(haddr[7:0]);
        addr_ok  = addr_dec[2] && (haddr[31:8] == 24'h00_0000);
        addr_idx = addr_dec[1:0];
        access   = hsel && hready && (htrans == qbpl_pkg::HTRANS_NONSEQ);
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, one instance per port

    genvar gi;
    generate
        for (gi = 0; gi < qbpl_pkg::NUM_PORTS; gi++) begin : g_port
            qbpl_pkg::qbpl_pin_s pins;    // this port's drive
            logic [7:0] alt_en;           // alternate output select
            logic [7:0] alt_val;          // alternate output value
            always_comb begin
                alt_en  = 8'h00;
                alt_val = 8'hff;
                if (gi == PORT_THREE_NUM) begin
                    alt_en[qbpl_pkg::TXD_BIT]  = uart_tx_en;
                    alt_val[qbpl_pkg::TXD_BIT] = uart_txd;
                end
            end
            qbpl_line u_line (
                .latch   (st_ff.latch_ff[gi]),
                .alt_en  (alt_en),
                .alt_val (alt_val),
                .pins    (pins)
            );
            assign pin_vec[gi*qbpl_pkg::PORT_W +: qbpl_pkg::PORT_W] = pins.pin_out;
            assign oe_vec[gi*qbpl_pkg::PORT_W +: qbpl_pkg::PORT_W]  = pins.pin_oe;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state: bus writes and read capture

    always_comb begin
        nxt_st = st_ff;
        // port three readback: bit 1 write-only reads 0
        p3_rd = pin_in[31:24];
        p3_rd[qbpl_pkg::TXD_BIT] = 1'b0;
        // data phase of a pending write
        if (st_ff.wr_pend_ff && st_ff.wr_ok_ff) begin
            if (st_ff.wr_idx_ff == PORT_THREE_IDX) begin
                // bit 0 is read-only, keep the latch
                nxt_st.latch_ff[3] = {hwdata[7:1], st_ff.latch_ff[3][qbpl_pkg::RXD_BIT]};
            end else begin
                nxt_st.latch_ff[st_ff.wr_idx_ff] = hwdata[7:0];
            end
        end
        nxt_st.wr_pend_ff = 1'b0;
        if (access) begin
            if (hwrite) begin
                nxt_st.wr_pend_ff = 1'b1;
                nxt_st.wr_idx_ff  = addr_idx;
                nxt_st.wr_ok_ff   = addr_ok;
            end else if (addr_ok) begin
                // reads return pin levels, so inputs are visible
                if (addr_idx == PORT_THREE_IDX) begin
                    nxt_st.rdata_ff = {24'h00_0000, p3_rd};
                end else begin
                    nxt_st.rdata_ff = {24'h00_0000, pin_in[addr_idx*8 +: 8]};
                end
            end else begin
                nxt_st.rdata_ff = 32'h0000_0000; // unmapped reads zero
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.latch_ff   <= {4{qbpl_pkg::LATCH_RESET}};
            st_ff.wr_pend_ff <= 1'b0;
            st_ff.wr_idx_ff  <= 2'd0;
            st_ff.wr_ok_ff   <= 1'b0;
            st_ff.rdata_ff   <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        hrdata    = st_ff.rdata_ff;
        hreadyout = 1'b1;                 // zero wait states
        hresp     = 1'b0;                 // always okay
        pin_out   = pin_vec;
        pin_oe    = oe_vec;
        uart_rxd               = pin_in[qbpl_pin_pos(PORT_THREE_NUM, qbpl_pkg::RXD_BIT)];
        ext_irq_zero_n         = pin_in[qbpl_pin_pos(PORT_THREE_NUM, qbpl_pkg::IRQ0_BIT)];
        ext_irq_one_n          = pin_in[qbpl_pin_pos(PORT_THREE_NUM, qbpl_pkg::IRQ1_BIT)];
        timer_zero_count_input = pin_in[qbpl_pin_pos(PORT_THREE_NUM, qbpl_pkg::T0_BIT)];
        timer_one_count_input  = pin_in[qbpl_pin_pos(PORT_THREE_NUM, qbpl_pkg::T1_BIT)];
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_reset_ones: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> st_ff.latch_ff == {4{qbpl_pkg::LATCH_RESET}})
        else $error("latches not ff after reset");

    chk_low_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.latch_ff[1][0] == 1'b0) |-> (pin_oe[8] && !pin_out[8]))
        else $error("zero latch not driving low");

    chk_weak_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.latch_ff[2] == 8'hff) |-> (pin_oe[23:16] == 8'h00))
        else $error("one latch driving pin");

    chk_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && hwrite && addr_ok && addr_idx == 2'd0) ##1 1'b1
        |=> st_ff.latch_ff[0] == $past(hwdata[7:0]))
        else $error("port zero write lost");

    chk_rxd_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.wr_pend_ff |=> $stable(st_ff.latch_ff[3][0]))
        else $error("read-only bit changed");

    chk_txd_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && !hwrite && addr_ok && addr_idx == 2'd3) |=> hrdata[1] == 1'b0)
        else $error("write-only bit read back");

    chk_txd_alt: assert property (@(posedge hclk) disable iff (!hresetn)
        (uart_tx_en && !uart_txd) |-> (pin_oe[25] && !pin_out[25]))
        else $error("uart transmit low not driven");

    chk_irq_map: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_irq_zero_n == pin_in[26]) && (ext_irq_one_n == pin_in[27]))
        else $error("irq inputs misrouted");

    chk_timer_map: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer_zero_count_input == pin_in[28]) && (timer_one_count_input == pin_in[29]))
        else $error("timer inputs misrouted");

    chk_irq0_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(pin_in[26]) |-> !ext_irq_zero_n)
        else $error("irq zero not following pin");

    chk_t0_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pin_in[28]) |-> timer_zero_count_input)
        else $error("timer zero not following pin");

    ////////////////////////////////////////////////////////////////////////
    // bus side checks
    // the slave never stalls and never errors

    chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout == 1'b1)
        else $error("slave stalled the bus");

    chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == 1'b0)
        else $error("slave gave an error response");

    chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    chk_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && !hwrite && !addr_ok) |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_unmapped_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && hwrite && !addr_ok) |=> ##1 $stable(st_ff.latch_ff))
        else $error("unmapped write changed a latch");

    chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(access && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");

    chk_idle_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
        !(access && hwrite) |=> !st_ff.wr_pend_ff)
        else $error("write pending without address phase");

    chk_port1_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && hwrite && addr_ok && addr_idx == 2'd1) ##1 1'b1
        |=> st_ff.latch_ff[1] == $past(hwdata[7:0]))
        else $error("port one write lost");

    chk_port2_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && hwrite && addr_ok && addr_idx == 2'd2) ##1 1'b1
        |=> st_ff.latch_ff[2] == $past(hwdata[7:0]))
        else $error("port two write lost");

    chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !st_ff.wr_pend_ff |=> $stable(st_ff.latch_ff))
        else $error("latch moved without a write");

    chk_port_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (access && !hwrite && addr_ok && addr_idx == 2'd0)
        |=> hrdata == {24'h00_0000, $past(pin_in[7:0])})
        else $error("port zero read not pin level");

    ////////////////////////////////////////////////////////////////////////
    // pin side checks
    // a line is either strong low or weakly high, never both

    chk_oe_low_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_oe & pin_out) == 32'h0000_0000)
        else $error("line driven high strongly");

    chk_oe_cover: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_oe | pin_out) == 32'hffff_ffff)
        else $error("line neither low nor released");

    chk_port2_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.latch_ff[2][7] == 1'b0) |-> pin_oe[23])
        else $error("port two zero not driving low");

    ////////////////////////////////////////////////////////////////////////
    // alternate function checks
    // port three inputs follow their pins in the same cycle

    chk_rxd_map: assert property (@(posedge hclk) disable iff (!hresetn)
        uart_rxd == pin_in[24])
        else $error("receive input misrouted");

    chk_irq1_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(pin_in[27]) |-> !ext_irq_one_n)
        else $error("irq one not following pin");

    chk_t1_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pin_in[29]) |-> timer_one_count_input)
        else $error("timer one not following pin");

    chk_p3_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.wr_pend_ff && st_ff.wr_ok_ff && st_ff.wr_idx_ff == PORT_THREE_IDX)
        |=> st_ff.latch_ff[3][7:1] == $past(hwdata[7:1]))
        else $error("port three write lost");

    chk_txd_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (uart_tx_en && uart_txd && st_ff.latch_ff[3][1]) |-> !pin_oe[25])
        else $error("uart transmit high driven low");

    chk_txd_latch_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.latch_ff[3][1] == 1'b0) |-> pin_oe[25])
        else $error("transmit latch zero not driving low");

endmodule : qbpl_top

/* verification/qbpl_pin_model.sv */
`timescale 1ns/10ps
// far side of the ports: weak pull-ups plus optional external drivers
module qbpl_pin_model (
    input  wire logic [31:0] pin_out, // level from the port
    input  wire logic [31:0] pin_oe,  // strong low enable
    input  wire logic [31:0] ext_en,  // external source active
    input  wire logic [31:0] ext_val, // external source level
    output logic      [31:0] pin_in   // resolved wire level
);
    // strong low wins, then an external source, then the pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule : qbpl_pin_model

/* verification/test_quasi_bidir_port_latches.sv */
`timescale 1ns/10ps
module test_quasi_bidir_port_latches;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, txd, tx_en;
    logic        dph_rd = 1'b0; // read data phase in progress
    logic [31:0] haddr, hwdata, hrdata, pin_in, pin_out, pin_oe, ext_en, ext_val;
    logic [1:0]  htrans;
    logic [4:0]  alt;           // t1, t0, irq1_n, irq0_n, rxd
    logic [7:0]  lat [4];       // expected latch values
    logic [7:0]  ofs [4] = '{qbpl_pkg::PORT_ZERO_OFS, qbpl_pkg::PORT_ONE_OFS,
                             qbpl_pkg::PORT_TWO_OFS, qbpl_pkg::PORT_THREE_OFS};
    logic [31:0] q [$];         // expected read data
    logic [7:0]  v;
    int          n_mismatch = 0;
    int          n_compared = 0;

    qbpl_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(qbpl_pkg::HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .uart_txd(txd), .uart_tx_en(tx_en), .uart_rxd(alt[0]),
        .timer_zero_count_input(alt[3]), .timer_one_count_input(alt[4]),
        .ext_irq_zero_n(alt[1]), .ext_irq_one_n(alt[2]));
    qbpl_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // compare helper
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // one single transfer, called just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        logic [23:0] fill;
        fill = 24'($urandom());
        hsel   <= 1'b1;
        htrans <= qbpl_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h0000_00, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {fill, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    // read with its expected value noted first
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back({24'h0000_00, e});
        bus(a, 1'b0, 8'h00);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // read data monitor: takes the oldest note at each read data phase end
    always @(posedge hclk) begin
        if (hreadyout === 1'b1) begin
            if (dph_rd && q.size() > 0) begin
                chk(hrdata, q.pop_front());
            end
            dph_rd <= hsel && htrans == qbpl_pkg::HTRANS_NONSEQ && !hwrite;
        end
    end

    // verdict and end of run
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // watchdog, far beyond the sixty-odd cycles of the tests
    initial begin
        #(3000 * 100);
        n_mismatch++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, txd, tx_en} = '0;
        {ext_en, ext_val} = '0;
        void'($urandom(74));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(pin_oe, 32'h0000_0000);
        for (int i = 0; i < 4; i++) rd(ofs[i], i == 3 ? 8'hfd : 8'hff);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            bus(ofs[i], 1'b1, v);
            lat[i] = i == 3 ? {v[7:1], 1'b1} : v;
        end
        bus(8'h84, 1'b1, 8'h00);
        rd(8'h84, 8'h00);
        for (int i = 0; i < 4; i++) rd(ofs[i], i == 3 ? lat[i] & 8'hfd : lat[i]);
        @(negedge hclk);
        chk(pin_oe, ~{lat[3], lat[2], lat[1], lat[0]});
        $display("test write done");
        @(posedge hclk);
        for (int i = 0; i < 4; i++) bus(ofs[i], 1'b1, 8'hff);
        for (int k = 0; k < 3; k++) begin
            v = $urandom();
            ext_en  <= 32'hff00_0000;
            ext_val <= {v, 24'h0000_00};
            @(posedge hclk);
            rd(qbpl_pkg::PORT_THREE_OFS, v & 8'hfd);
            chk({27'h0, alt}, {27'h0, v[5], v[4], v[3], v[2], v[0]});
        end
        $display("test alternate inputs done");
        ext_en <= 32'h0000_0000;
        tx_en  <= 1'b1;
        @(negedge hclk);
        chk({31'h0, pin_oe[25]}, 32'h0000_0001);
        @(posedge hclk);
        txd <= 1'b1;
        @(negedge hclk);
        chk({31'h0, pin_oe[25]}, 32'h0000_0000);
        $display("test transmit done");
        @(posedge hclk);
        bus(qbpl_pkg::PORT_ZERO_OFS, 1'b1, 8'h00);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk(pin_oe, 32'h0000_0000);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(qbpl_pkg::PORT_ZERO_OFS, 8'hff);
        chk({31'h0, hresp}, 32'h0000_0000);
        @(negedge hclk);
        $display("test reset again done");
        test_done();
    end
endmodule : test_quasi_bidir_port_latches
